// File: design/vic_pkg.sv
// Package: constants and types of the vectored interrupt controller
package vic_pkg;
    localparam int NUM_SRC      = 10;
    localparam int NUM_MASKABLE = 9;
    localparam int VEC_W        = 16;

    // Vector table addresses
    localparam logic [15:0] VEC_NMI    = 16'h0004;
    localparam logic [15:0] VEC_WDT    = 16'h0004;
    localparam logic [15:0] VEC_EXT0   = 16'h0006;
    localparam logic [15:0] VEC_EXT1   = 16'h0008;
    localparam logic [15:0] VEC_EXT2   = 16'h000a;
    localparam logic [15:0] VEC_SERRX  = 16'h000c;
    localparam logic [15:0] VEC_SERTX  = 16'h000e;
    localparam logic [15:0] VEC_TMR8   = 16'h0010;
    localparam logic [15:0] VEC_TMR16  = 16'h0012;
    localparam logic [15:0] VEC_ADC    = 16'h0014;
    localparam logic [15:0] VEC_TBL_LO = 16'h0000;
    localparam logic [15:0] VEC_TBL_HI = 16'h0015;

    // Priority levels (pending bit index = level)
    localparam int LVL_WDT   = 0;
    localparam int LVL_EXT0  = 1;
    localparam int LVL_EXT1  = 2;
    localparam int LVL_EXT2  = 3;
    localparam int LVL_SER   = 4;
    localparam int LVL_SERTX = 5;
    localparam int LVL_TMR8  = 6;
    localparam int LVL_TMR16 = 7;
    localparam int LVL_ADC   = 8;

    // Register byte addresses
    localparam logic [7:0] OFF_PEND   = 8'h00;
    localparam logic [7:0] OFF_MASK   = 8'h04;
    localparam logic [7:0] OFF_CTRL   = 8'h08;
    localparam logic [7:0] OFF_EDGE   = 8'h0c;
    localparam logic [7:0] OFF_STAT   = 8'h10;
    localparam logic [7:0] OFF_EVMASK = 8'h14;
    localparam logic [7:0] OFF_VEC    = 8'h18;

    // Field positions and reset values
    localparam int CTRL_GIE_BIT    = 0;
    localparam int CTRL_WDTNMI_BIT = 1;
    localparam logic [8:0]  MASK_RST = 9'h1ff;
    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam logic [5:0]  EDGE_RST = 6'h00;
    localparam int EV_NMI_BIT = 0;
    localparam int EV_IRQ_BIT = 1;

    typedef enum logic [1:0] {
        VIC_EDGE_NONE,
        VIC_EDGE_RISE,
        VIC_EDGE_FALL,
        VIC_EDGE_BOTH
    } vic_edge_t;

    typedef struct packed {
        logic       req;
        logic       nmi;
        logic [15:0] vector;
    } vic_cpu_req_t;
endpackage

// File: design/vic_edge_det.sv
// Edge detector for one external request pin
`timescale 1ns/10ps
module vic_edge_det (
    input  wire logic                clock_i, // System clock
    input  wire logic                rst_i,   // Async reset, high
    input  wire logic                pin_i,   // Request pin level
    input  wire vic_pkg::vic_edge_t  sel_i,   // Valid edge choice
    output logic                     hit_o    // One-cycle edge pulse
);
    logic pin_r;
    logic pin_nxt;

    always_comb begin
        pin_nxt = pin_i;
        unique case (sel_i)
            vic_pkg::VIC_EDGE_NONE: hit_o = 1'b0;
            vic_pkg::VIC_EDGE_RISE: hit_o = pin_i & ~pin_r;
            vic_pkg::VIC_EDGE_FALL: hit_o = ~pin_i & pin_r;
            vic_pkg::VIC_EDGE_BOTH: hit_o = pin_i ^ pin_r;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    default clocking cb_sva @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_rise_edge : assert property (
        (sel_i == vic_pkg::VIC_EDGE_RISE && hit_o) |-> !$past(pin_i))
        else $error("rise pulse without low-to-high pin");
endmodule

// File: design/vic_prio_enc.sv
// Fixed-priority encoder: lowest index wins
`timescale 1ns/10ps
module vic_prio_enc #(
    parameter int N = 9
) (
    input  wire logic [N-1:0]         req_i,   // Qualified requests
    output logic                      any_o,   // Any request
    output logic [$clog2(N)-1:0]      idx_o    // Winning index
);
    initial begin
        if (N < 2) $error("vic_prio_enc needs N of at least 2");
    end

    always_comb begin
        any_o = 1'b0;
        idx_o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                idx_o = ($clog2(N))'(i);
            end
        end
    end
endmodule

// File: design/vic_top.sv
// Vectored interrupt controller with APB register access
//
// Function
// - Ten sources: one non-maskable, nine maskable
// - Lowest level number wins among pending
// - Watchdog mode overflow gives NMI at 0004
// - Interval mode overflow gives level 0
// - Three edge pins at levels 1-3
// - Edge choice: rising, falling or both
// - Serial receive and transfer share level 4
// - Serial transmit done at level 5
// - Eight-bit timer match at level 6
// - Sixteen-bit timer match at level 7
// - Conversion done at level 8
// - Vector table spans 0000 to 0015
`timescale 1ns/10ps
module vic_top #(
    parameter int NUM_MASK = 9
) (
    input  wire logic        clock_i,              // System clock
    input  wire logic        rst_i,                // Async reset, high
    input  wire logic        psel_i,               // APB select
    input  wire logic        penable_i,            // APB enable
    input  wire logic        pwrite_i,             // APB direction
    input  wire logic [7:0]  paddr_i,              // APB byte address
    input  wire logic [31:0] pwdata_i,             // APB write data
    output logic [31:0]      prdata_o,             // APB read data
    output logic             pready_o,             // APB ready
    output logic             pslverr_o,            // APB error
    input  wire logic        watchdog_overflow_irq_i, // Watchdog overflow
    input  wire logic        ext_edge_irq_0_i,     // External pin 0
    input  wire logic        ext_edge_irq_1_i,     // External pin 1
    input  wire logic        ext_edge_irq_2_i,     // External pin 2
    input  wire logic        serial_rx_done_irq_i, // Receive done pulse
    input  wire logic        sync_xfer_done_irq_i, // Transfer done pulse
    input  wire logic        serial_tx_done_irq_i, // Transmit done pulse
    input  wire logic        timer8_match_irq_i,   // 8-bit timer match
    input  wire logic        timer16_match_irq_i,  // 16-bit timer match
    input  wire logic        adc_done_irq_i,       // Conversion done
    input  wire logic        cpu_ack_i,            // CPU takes request
    output vic_pkg::vic_cpu_req_t cpu_req_o,       // Request to CPU
    output logic             irq_o                 // Summary interrupt
);
    initial begin
        if (NUM_MASK != vic_pkg::NUM_MASKABLE)
            $error("vic_top supports exactly nine maskable sources");
    end

    localparam int IW = $clog2(NUM_MASK);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [NUM_MASK-1:0] pend_r, pend_nxt;
    logic [NUM_MASK-1:0] mask_r, mask_nxt;
    logic [1:0]          ctrl_r, ctrl_nxt;
    logic [5:0]          edge_r, edge_nxt;
    logic                nmi_r, nmi_nxt;
    logic [1:0]          stat_r, stat_nxt;
    logic [1:0]          evm_r, evm_nxt;
    logic [31:0]         rdata_r, rdata_nxt;
    vic_pkg::vic_cpu_req_t out_r, out_nxt;

    logic [2:0]          ext_hit;
    logic [2:0]          ext_pin;
    logic [NUM_MASK-1:0] src_set;
    logic [NUM_MASK-1:0] qual;
    logic                any_q;
    logic [IW-1:0]       win_idx;
    logic                wr_acc, rd_acc, rd_setup, mapped;
    logic                wdt_nmi_mode, gie;
    logic [15:0]         vec_tbl [NUM_MASK];

    assign wdt_nmi_mode = ctrl_r[vic_pkg::CTRL_WDTNMI_BIT];
    assign gie          = ctrl_r[vic_pkg::CTRL_GIE_BIT];
    assign ext_pin      = {ext_edge_irq_2_i, ext_edge_irq_1_i,
                           ext_edge_irq_0_i};

    // ------------------------------------------------------------------
    // External edge detection
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_ext
        vic_edge_det u_edge (
            .clock_i (clock_i),
            .rst_i   (rst_i),
            .pin_i   (ext_pin[g]),
            .sel_i   (vic_pkg::vic_edge_t'(edge_r[2*g +: 2])),
            .hit_o   (ext_hit[g])
        );
    end

    // ------------------------------------------------------------------
    // Source routing onto levels
    // ------------------------------------------------------------------
    always_comb begin
        src_set = '0;
        src_set[vic_pkg::LVL_WDT]   = watchdog_overflow_irq_i
                                      & ~wdt_nmi_mode;
        src_set[vic_pkg::LVL_EXT0]  = ext_hit[0];
        src_set[vic_pkg::LVL_EXT1]  = ext_hit[1];
        src_set[vic_pkg::LVL_EXT2]  = ext_hit[2];
        src_set[vic_pkg::LVL_SER]   = serial_rx_done_irq_i
                                      | sync_xfer_done_irq_i;
        src_set[vic_pkg::LVL_SERTX] = serial_tx_done_irq_i;
        src_set[vic_pkg::LVL_TMR8]  = timer8_match_irq_i;
        src_set[vic_pkg::LVL_TMR16] = timer16_match_irq_i;
        src_set[vic_pkg::LVL_ADC]   = adc_done_irq_i;
    end

    // Vector table; every entry lies inside 0000..0015
    always_comb begin
        vec_tbl[vic_pkg::LVL_WDT]   = vic_pkg::VEC_WDT;
        vec_tbl[vic_pkg::LVL_EXT0]  = vic_pkg::VEC_EXT0;
        vec_tbl[vic_pkg::LVL_EXT1]  = vic_pkg::VEC_EXT1;
        vec_tbl[vic_pkg::LVL_EXT2]  = vic_pkg::VEC_EXT2;
        vec_tbl[vic_pkg::LVL_SER]   = vic_pkg::VEC_SERRX;
        vec_tbl[vic_pkg::LVL_SERTX] = vic_pkg::VEC_SERTX;
        vec_tbl[vic_pkg::LVL_TMR8]  = vic_pkg::VEC_TMR8;
        vec_tbl[vic_pkg::LVL_TMR16] = vic_pkg::VEC_TMR16;
        vec_tbl[vic_pkg::LVL_ADC]   = vic_pkg::VEC_ADC;
    end

    assign qual = pend_r & ~mask_r & {NUM_MASK{gie}};

    vic_prio_enc #(
        .N (NUM_MASK)
    ) u_prio (
        .req_i (qual),
        .any_o (any_q),
        .idx_o (win_idx)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign rd_acc = psel_i & penable_i & ~pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    always_comb begin
        unique case (paddr_i)
            vic_pkg::OFF_PEND, vic_pkg::OFF_MASK, vic_pkg::OFF_CTRL,
            vic_pkg::OFF_EDGE, vic_pkg::OFF_STAT, vic_pkg::OFF_EVMASK,
            vic_pkg::OFF_VEC: mapped = 1'b1;
            default:          mapped = 1'b0;
        endcase
    end
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign prdata_o  = rdata_r;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        pend_nxt  = pend_r;
        mask_nxt  = mask_r;
        ctrl_nxt  = ctrl_r;
        edge_nxt  = edge_r;
        nmi_nxt   = nmi_r;
        stat_nxt  = stat_r;
        evm_nxt   = evm_r;
        rdata_nxt = 32'h0000_0000;
        out_nxt   = out_r;

        // Register writes; software clear of a pending bit is write-1
        if (wr_acc) begin
            unique case (paddr_i)
                vic_pkg::OFF_PEND:   pend_nxt = pend_r
                                         & ~pwdata_i[NUM_MASK-1:0];
                vic_pkg::OFF_MASK:   mask_nxt = pwdata_i[NUM_MASK-1:0];
                vic_pkg::OFF_CTRL:   ctrl_nxt = pwdata_i[1:0];
                vic_pkg::OFF_EDGE:   edge_nxt = pwdata_i[5:0];
                vic_pkg::OFF_EVMASK: evm_nxt  = pwdata_i[1:0];
                default: ;
            endcase
        end
        if (rd_acc && paddr_i == vic_pkg::OFF_STAT) stat_nxt = 2'h0;

        // CPU acceptance retires the request that was presented
        if (cpu_ack_i && out_r.req) begin
            if (out_r.nmi) nmi_nxt = 1'b0;
            else pend_nxt[win_idx] = 1'b0;
        end

        // Hardware sets win over any clear in the same cycle
        pend_nxt = pend_nxt | src_set;
        if (watchdog_overflow_irq_i && wdt_nmi_mode) nmi_nxt = 1'b1;

        // NMI bypasses masks and global enable
        if (nmi_nxt) begin
            out_nxt.req    = 1'b1;
            out_nxt.nmi    = 1'b1;
            out_nxt.vector = vic_pkg::VEC_NMI;
        end else if (|(pend_nxt & ~mask_nxt & {NUM_MASK{ctrl_nxt[0]}}))
        begin
            out_nxt.req    = 1'b1;
            out_nxt.nmi    = 1'b0;
            out_nxt.vector = vic_pkg::VEC_TBL_LO;
            for (int i = NUM_MASK - 1; i >= 0; i--) begin
                if (pend_nxt[i] && !mask_nxt[i] && ctrl_nxt[0])
                    out_nxt.vector = vec_tbl[i];
            end
        end else begin
            out_nxt.req    = 1'b0;
            out_nxt.nmi    = 1'b0;
            out_nxt.vector = vic_pkg::VEC_TBL_LO;
        end

        // Sticky event status for the summary interrupt
        if (watchdog_overflow_irq_i && wdt_nmi_mode)
            stat_nxt[vic_pkg::EV_NMI_BIT] = 1'b1;
        if (|src_set)
            stat_nxt[vic_pkg::EV_IRQ_BIT] = 1'b1;

        // Latched in setup so it stands through the access cycle; next
        // values keep events of that edge, later ones survive the clear
        if (rd_setup) begin
            unique case (paddr_i)
                vic_pkg::OFF_PEND:   rdata_nxt = 32'(pend_nxt);
                vic_pkg::OFF_MASK:   rdata_nxt = 32'(mask_nxt);
                vic_pkg::OFF_CTRL:   rdata_nxt = 32'(ctrl_nxt);
                vic_pkg::OFF_EDGE:   rdata_nxt = 32'(edge_nxt);
                vic_pkg::OFF_STAT:   rdata_nxt = 32'(stat_nxt);
                vic_pkg::OFF_EVMASK: rdata_nxt = 32'(evm_nxt);
                vic_pkg::OFF_VEC:    rdata_nxt = 32'(out_nxt.vector);
                default:             rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r  <= '0;
            mask_r  <= vic_pkg::MASK_RST;
            ctrl_r  <= vic_pkg::CTRL_RST;
            edge_r  <= vic_pkg::EDGE_RST;
            nmi_r   <= 1'b0;
            stat_r  <= 2'h0;
            evm_r   <= 2'h0;
            rdata_r <= 32'h0000_0000;
            out_r   <= '0;
        end else begin
            pend_r  <= pend_nxt;
            mask_r  <= mask_nxt;
            ctrl_r  <= ctrl_nxt;
            edge_r  <= edge_nxt;
            nmi_r   <= nmi_nxt;
            stat_r  <= stat_nxt;
            evm_r   <= evm_nxt;
            rdata_r <= rdata_nxt;
            out_r   <= out_nxt;
        end
    end

    assign cpu_req_o = out_r;
    assign irq_o     = |(stat_r & ~evm_r);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb_sva @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_src_count : assert property (
        $bits(src_set) + 1 == vic_pkg::NUM_SRC)
        else $error("source count is not ten");

    a_prio_win : assert property (
        (any_q && !out_r.nmi && out_r.req) |->
        out_r.vector == vec_tbl[win_idx])
        else $error("presented vector is not highest priority");

    a_nmi_vec : assert property (
        (watchdog_overflow_irq_i && wdt_nmi_mode) |=>
        cpu_req_o.nmi && cpu_req_o.vector == 16'h0004)
        else $error("watchdog overflow did not give nmi");

    a_wdt_mask : assert property (
        (watchdog_overflow_irq_i && !wdt_nmi_mode) |=> pend_r[0])
        else $error("interval overflow did not pend level 0");

    a_ext_pend : assert property (
        ext_hit[1] |=> pend_r[vic_pkg::LVL_EXT1])
        else $error("edge on pin 1 not pending");

    a_ser_share : assert property (
        sync_xfer_done_irq_i |=> pend_r[4])
        else $error("transfer done did not pend level 4");

    a_tx_pend : assert property (
        serial_tx_done_irq_i |=> pend_r[5])
        else $error("transmit done did not pend level 5");

    a_vec_range : assert property (
        cpu_req_o.req |-> cpu_req_o.vector <= 16'h0015)
        else $error("vector outside table");

    a_gate_mask : assert property (
        (cpu_req_o.req && !cpu_req_o.nmi) |-> gie)
        else $error("maskable request with global enable clear");

    a_nmi_bypass : assert property (
        nmi_r |-> cpu_req_o.req)
        else $error("nmi blocked");
endmodule

// File: tb/vic_cpu_model.sv
// Partner model: CPU core that takes presented vectored requests
`timescale 1ns/10ps
module vic_cpu_model (
    input  wire logic                  clock_i, // System clock
    input  wire logic                  rst_i,   // Async reset, high
    input  wire vic_pkg::vic_cpu_req_t req_i,   // Request from controller
    input  wire logic [3:0]            delay_i, // Wait cycles before taking
    output logic                       ack_o,   // One-cycle take pulse
    output logic [15:0]                vec_o,   // Last vector taken
    output logic                       nmi_o,   // Last take was non-maskable
    output logic [15:0]                taken_o  // Takes so far
);
    logic [3:0] wait_r;

    // Vector is captured at the edge that samples the take pulse, while
    // the controller still presents it; never two pulses back to back
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o   <= 1'b0;
            vec_o   <= 16'h0000;
            nmi_o   <= 1'b0;
            taken_o <= 16'h0000;
            wait_r  <= 4'h0;
        end else if (ack_o) begin
            ack_o   <= 1'b0;
            vec_o   <= req_i.vector;
            nmi_o   <= req_i.nmi;
            taken_o <= taken_o + 16'h0001;
            wait_r  <= 4'h0;
        end else if (req_i.req) begin
            if (wait_r >= delay_i) begin
                ack_o <= 1'b1;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// File: tb/tb.sv
// Testbench of the vectored interrupt controller
`timescale 1ns/10ps
module tb;
    localparam int LIMIT = 20000;
    logic        clock_i, rst_i, psel, penable, pwrite, pready, pslverr;
    logic        irq, ack, last_nmi;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  src;
    logic [3:0]  ack_delay;
    logic [15:0] last_vec, n_taken;
    vic_pkg::vic_cpu_req_t cpu_req;
    int          failures, n_compared, cycles;

    vic_top u_dut (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .watchdog_overflow_irq_i(src[0]), .ext_edge_irq_0_i(src[1]),
        .ext_edge_irq_1_i(src[2]), .ext_edge_irq_2_i(src[3]),
        .serial_rx_done_irq_i(src[4]), .sync_xfer_done_irq_i(src[5]),
        .serial_tx_done_irq_i(src[6]), .timer8_match_irq_i(src[7]),
        .timer16_match_irq_i(src[8]), .adc_done_irq_i(src[9]),
        .cpu_ack_i(ack), .cpu_req_o(cpu_req), .irq_o(irq)
    );

    vic_cpu_model u_cpu (
        .clock_i(clock_i), .rst_i(rst_i), .req_i(cpu_req),
        .delay_i(ack_delay), .ack_o(ack), .vec_o(last_vec),
        .nmi_o(last_nmi), .taken_o(n_taken)
    );

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Read data and error taken at the edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic err);
        @(posedge clock_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        check("pslverr", {31'h0, pslverr}, {31'h0, err});
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic rd_chk(input string w, input logic [7:0] a,
                          input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b0);
        check(w, rd, e);
    endtask

    task automatic pulse(input logic [9:0] m);
        @(posedge clock_i);
        src <= src | m;
        @(posedge clock_i);
        src <= src & ~m;
    endtask

    // Bounded wait: a request that never comes is judged after 12 cycles
    task automatic take(input logic want, input logic [15:0] vec,
                        input logic nmi);
        logic [15:0] n0;
        int k;
        n0 = n_taken;
        k = 0;
        while (n_taken === n0 && k < 12) begin
            @(posedge clock_i);
            k++;
        end
        check("taken", {31'h0, n_taken !== n0}, {31'h0, want});
        if (want) begin
            check("vector", {16'h0, last_vec}, {16'h0, vec});
            check("nmi", {31'h0, last_nmi}, {31'h0, nmi});
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("cpu_req", {14'h0, cpu_req}, 32'h0);
        rd_chk("mask", vic_pkg::OFF_MASK, 32'h1ff);
        rd_chk("ctrl", vic_pkg::OFF_CTRL, 32'h0);
        rd_chk("edge", vic_pkg::OFF_EDGE, 32'h0);
        rd_chk("pend", vic_pkg::OFF_PEND, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, 1'b1);
        check("unmapped", rd, 32'h0);
        wr(vic_pkg::OFF_EVMASK, 32'h0);
        wr(vic_pkg::OFF_MASK, 32'h0);
        $display("test reset done");
    endtask

    // Six sources at once while disabled, level 8 cleared by write-1, the other five served in level order
    task automatic t_prio();
        pulse(10'h3d1);
        take(1'b0, 16'h0, 1'b0);
        rd_chk("pend", vic_pkg::OFF_PEND, 32'h1f1);
        wr(vic_pkg::OFF_PEND, 32'h100);
        rd_chk("pend_w1c", vic_pkg::OFF_PEND, 32'h0f1);
        wr(vic_pkg::OFF_CTRL, 32'h1);
        take(1'b1, 16'h0004, 1'b0);
        take(1'b1, 16'h000c, 1'b0);
        take(1'b1, 16'h000e, 1'b0);
        take(1'b1, 16'h0010, 1'b0);
        take(1'b1, 16'h0012, 1'b0);
        take(1'b0, 16'h0, 1'b0);
        pulse(10'h020);
        take(1'b1, 16'h000c, 1'b0);
        pulse(10'h200);
        take(1'b1, 16'h0014, 1'b0);
        rd_chk("pend_idle", vic_pkg::OFF_PEND, 32'h0);
        $display("test priority done");
    endtask

    task automatic t_mask();
        apb(1'b0, vic_pkg::OFF_STAT, 32'h0, 1'b0);
        wr(vic_pkg::OFF_MASK, 32'h040);
        pulse(10'h080);
        take(1'b0, 16'h0, 1'b0);
        check("irq_set", {31'h0, irq}, 32'h1);
        rd_chk("stat", vic_pkg::OFF_STAT, 32'h2);
        @(posedge clock_i);
        check("irq_clr", {31'h0, irq}, 32'h0);
        wr(vic_pkg::OFF_CTRL, 32'h0);
        wr(vic_pkg::OFF_MASK, 32'h0);
        take(1'b0, 16'h0, 1'b0);
        ack_delay <= 4'h8;
        wr(vic_pkg::OFF_CTRL, 32'h1);
        rd_chk("vector_reg", vic_pkg::OFF_VEC, 32'h0010);
        take(1'b1, 16'h0010, 1'b0);
        ack_delay <= 4'h0;
        $display("test mask done");
    endtask

    // Watchdog mode: presented although all masked and disabled
    task automatic t_nmi();
        wr(vic_pkg::OFF_MASK, 32'h1ff);
        wr(vic_pkg::OFF_CTRL, 32'h2);
        apb(1'b0, vic_pkg::OFF_STAT, 32'h0, 1'b0);
        pulse(10'h001);
        take(1'b1, 16'h0004, 1'b1);
        check("irq_nmi", {31'h0, irq}, 32'h1);
        rd_chk("stat_nmi", vic_pkg::OFF_STAT, 32'h1);
        rd_chk("pend_nmi", vic_pkg::OFF_PEND, 32'h0);
        wr(vic_pkg::OFF_EVMASK, 32'h1);
        pulse(10'h001);
        take(1'b1, 16'h0004, 1'b1);
        check("irq_evm", {31'h0, irq}, 32'h0);
        rd_chk("stat_evm", vic_pkg::OFF_STAT, 32'h1);
        $display("test nmi done");
    endtask

    // Every pin in every edge choice, with a slow taker
    task automatic t_edge();
        logic [1:0] m;
        wr(vic_pkg::OFF_MASK, 32'h0);
        wr(vic_pkg::OFF_CTRL, 32'h1);
        ack_delay <= 4'h3;
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 4; i++) begin
                m = 2'(i);
                wr(vic_pkg::OFF_EDGE, 32'(m) << (2 * p));
                @(posedge clock_i);
                src[1+p] <= 1'b1;
                take(m[0], 16'(6 + 2 * p), 1'b0);
                @(posedge clock_i);
                src[1+p] <= 1'b0;
                take(m[1], 16'(6 + 2 * p), 1'b0);
            end
        end
        $display("test edge done");
    endtask

    initial begin
        rst_i     = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        src       = 10'h000;
        ack_delay = 4'h0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_prio();
        t_mask();
        t_nmi();
        t_edge();
        close_out();
    end
endmodule
